// File: logic/pmbus_regs_pkg.sv
package pmbus_regs_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Command codes
   localparam logic [7:0] CODE_OPERATION = 8'h01;
   localparam logic [7:0] CODE_ONOFF_CFG = 8'h02;
   localparam logic [7:0] CODE_FAULT_CLEAR = 8'h03;
   localparam logic [7:0] CODE_WRITE_LOCK = 8'h10;
   localparam logic [7:0] CODE_RESTORE_FACTORY = 8'h12;
   localparam logic [7:0] CODE_STORE_USER = 8'h15;
   localparam logic [7:0] CODE_RESTORE_USER = 8'h16;
   localparam logic [7:0] CODE_BUS_CAPS = 8'h19;
   localparam logic [7:0] CODE_VOUT_FORMAT = 8'h20;
   localparam logic [7:0] CODE_VOUT_SETPOINT = 8'h21;
   localparam logic [7:0] CODE_LOOP_SCALE = 8'h29;
   localparam logic [7:0] CODE_MONITOR_SCALE = 8'h2a;
   localparam logic [7:0] CODE_PAGE_ERASE = 8'hd0;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int ONOFF_POWERUP_BIT = 4;
   localparam int ONOFF_CMD_EN_BIT = 3;
   localparam int ONOFF_PIN_EN_BIT = 2;
   localparam int ONOFF_POLARITY_BIT = 1;
   localparam int LOCK_ALL_BIT = 7;
   localparam int LOCK_OPS_BIT = 6;
   localparam int LOCK_CFG_BIT = 5;
   localparam int OPERATION_ON_BIT = 7;
   localparam int SCALE_EXP_LSB = 11;
   localparam int SETPOINT_WIDTH = 12;
   localparam int SCALE_MANT_WIDTH = 10;
   localparam int LOOP_EXP_WIDTH = 5;
   localparam int MONITOR_EXP_WIDTH = 3;
   localparam int FORMAT_EXP_WIDTH = 3;

   ////////////////////////////////////////////////////////////////////////////
   // Fixed read values and reset values
   localparam logic [7:0] CAPS_VALUE = 8'h20;
   localparam logic [2:0] FORMAT_MODE_LINEAR = 3'h0;
   localparam logic [7:0] OPERATION_FIXED = 8'h04;
   localparam logic [3:0] ONOFF_RST = 4'hf;
   localparam logic [2:0] LOCK_RST = 3'h0;
   localparam logic OPERATION_RST = 1'b0;
   localparam logic [2:0] FORMAT_EXP_RST = 3'h0;
   localparam logic [11:0] SETPOINT_RST = 12'h000;
   localparam logic [15:0] LOOP_SCALE_RST = 16'h0000;
   localparam logic [12:0] MONITOR_SCALE_RST = 13'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic valid;
      logic is_write;
      logic is_send;
      logic [7:0] code;
      logic [15:0] data;
   } cmd_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] code;
      logic [15:0] data;
   } nv_load_t;

endpackage

// File: logic/pmbus_onoff_protect_format_regs.sv
`timescale 1ns/100ps
// What this block does
// - Power-up bit picks always-on or commanded start
// - Command-enable bit gates the operation command
// - Pin-enable bit gates the supply-on pin
// - Polarity bit sets supply-on pin active level
// - Power-down bit reads one; off is immediate
// - Send-byte 0x03 clears all fault bits
// - Lock bit 7 allows only lock register writes
// - Lock bit 6 adds operation and page erase
// - Lock bit 5 adds on/off config and setpoint
// - Send-byte 0x12 restores factory defaults
// - Send-byte 0x15 stores working registers
// - Send-byte 0x16 restores user settings
// - Capability bit 7 reads zero
// - Capability bits 6:5 read 01
// - Capability bit 4 reads zero
// - Format mode field fixed to linear
// - Format bits 2:0 hold writable exponent
// - Setpoint high nibble zero, mantissa writable
// - Loop scale exponent 15:11, mantissa 9:0
// - Monitor scale exponent 13:11, mantissa 9:0
// - Operation bit 7 turns device on/off
module pmbus_onoff_protect_format_regs (
   input wire logic ref_clk,
   input wire logic reset_n,
   input pmbus_regs_pkg::cmd_req_t cmd_req,
   input pmbus_regs_pkg::nv_load_t nv_load,
   input wire logic supply_on_request_pin,
   output logic rd_valid_q,
   output logic [15:0] rd_data_q,
   output logic rd_miss_q,
   output logic wr_reject_q,
   output logic fault_clear_q,
   output logic restore_factory_q,
   output logic store_user_q,
   output logic restore_user_q,
   output logic page_erase_q,
   output logic device_enable_q,
   output logic [11:0] setpoint_mant_q,
   output logic [2:0] format_exp_q
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release and pin synchroniser

   logic rst_s1_q;
   logic rst_n_q;
   logic pin_s1_q;
   logic pin_s2_q;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
      end else begin
         pin_s1_q <= supply_on_request_pin;
         pin_s2_q <= pin_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write qualification

   logic [3:0] onoff_q;
   logic [2:0] lock_q;
   logic op_on_q;
   logic [15:0] loop_scale_q;
   logic [12:0] monitor_scale_q;

   function automatic logic write_allowed(input logic [7:0] code, input logic [2:0] lock);
      logic ok;
      ok = 1'b1;
      if (code != pmbus_regs_pkg::CODE_WRITE_LOCK) begin
         if (lock[2]) begin
            ok = 1'b0;
         end else if (lock[1]) begin
            ok = (code == pmbus_regs_pkg::CODE_OPERATION) ||
                 (code == pmbus_regs_pkg::CODE_PAGE_ERASE);
         end else if (lock[0]) begin
            ok = (code == pmbus_regs_pkg::CODE_OPERATION) ||
                 (code == pmbus_regs_pkg::CODE_PAGE_ERASE) ||
                 (code == pmbus_regs_pkg::CODE_ONOFF_CFG) ||
                 (code == pmbus_regs_pkg::CODE_VOUT_SETPOINT);
         end
      end
      return ok;
   endfunction

   function automatic logic is_writable(input logic [7:0] code);
      return (code == pmbus_regs_pkg::CODE_OPERATION) ||
             (code == pmbus_regs_pkg::CODE_ONOFF_CFG) ||
             (code == pmbus_regs_pkg::CODE_WRITE_LOCK) ||
             (code == pmbus_regs_pkg::CODE_VOUT_FORMAT) ||
             (code == pmbus_regs_pkg::CODE_VOUT_SETPOINT) ||
             (code == pmbus_regs_pkg::CODE_LOOP_SCALE) ||
             (code == pmbus_regs_pkg::CODE_MONITOR_SCALE) ||
             (code == pmbus_regs_pkg::CODE_PAGE_ERASE);
   endfunction

   logic host_write;
   logic host_read;
   logic host_send;
   logic host_ok;
   logic upd_en;
   logic [7:0] upd_code;
   logic [15:0] upd_data;

   assign host_write = cmd_req.valid && cmd_req.is_write && !cmd_req.is_send;
   assign host_read = cmd_req.valid && !cmd_req.is_write && !cmd_req.is_send;
   assign host_send = cmd_req.valid && cmd_req.is_send;
   assign host_ok = host_write && is_writable(cmd_req.code) &&
                    write_allowed(cmd_req.code, lock_q);

   // A nonvolatile load bypasses the lock; it wins over a host write in the same cycle
   assign upd_en = nv_load.valid || host_ok;
   assign upd_code = nv_load.valid ? nv_load.code : cmd_req.code;
   assign upd_data = nv_load.valid ? nv_load.data : cmd_req.data;

   ////////////////////////////////////////////////////////////////////////////
   // Working registers

   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         onoff_q <= pmbus_regs_pkg::ONOFF_RST;
      end else if (upd_en && upd_code == pmbus_regs_pkg::CODE_ONOFF_CFG) begin
         onoff_q <= upd_data[4:1];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         lock_q <= pmbus_regs_pkg::LOCK_RST;
      end else if (upd_en && upd_code == pmbus_regs_pkg::CODE_WRITE_LOCK) begin
         lock_q <= upd_data[7:5];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         op_on_q <= pmbus_regs_pkg::OPERATION_RST;
      end else if (upd_en && upd_code == pmbus_regs_pkg::CODE_OPERATION) begin
         op_on_q <= upd_data[pmbus_regs_pkg::OPERATION_ON_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         format_exp_q <= pmbus_regs_pkg::FORMAT_EXP_RST;
      end else if (upd_en && upd_code == pmbus_regs_pkg::CODE_VOUT_FORMAT) begin
         format_exp_q <= upd_data[2:0];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         setpoint_mant_q <= pmbus_regs_pkg::SETPOINT_RST;
      end else if (upd_en && upd_code == pmbus_regs_pkg::CODE_VOUT_SETPOINT) begin
         setpoint_mant_q <= upd_data[11:0];
      end
   end

   // Bit 10 is held at zero in the loop scale and not stored in the monitor scale, so it cannot read back as one
   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         loop_scale_q <= pmbus_regs_pkg::LOOP_SCALE_RST;
      end else if (upd_en && upd_code == pmbus_regs_pkg::CODE_LOOP_SCALE) begin
         loop_scale_q <= {upd_data[15:11], 1'b0, upd_data[9:0]};
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         monitor_scale_q <= pmbus_regs_pkg::MONITOR_SCALE_RST;
      end else if (upd_en && upd_code == pmbus_regs_pkg::CODE_MONITOR_SCALE) begin
         monitor_scale_q <= {upd_data[13:11], upd_data[9:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Send-byte and protected-write pulses

   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         fault_clear_q <= 1'b0;
         restore_factory_q <= 1'b0;
         store_user_q <= 1'b0;
         restore_user_q <= 1'b0;
      end else begin
         fault_clear_q <= host_send && cmd_req.code == pmbus_regs_pkg::CODE_FAULT_CLEAR;
         restore_factory_q <= host_send &&
                              cmd_req.code == pmbus_regs_pkg::CODE_RESTORE_FACTORY;
         store_user_q <= host_send && cmd_req.code == pmbus_regs_pkg::CODE_STORE_USER;
         restore_user_q <= host_send &&
                           cmd_req.code == pmbus_regs_pkg::CODE_RESTORE_USER;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         page_erase_q <= 1'b0;
         wr_reject_q <= 1'b0;
      end else begin
         page_erase_q <= host_ok && cmd_req.code == pmbus_regs_pkg::CODE_PAGE_ERASE;
         wr_reject_q <= host_write && !host_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Enable decision

   logic pin_active;
   logic cmd_cond;
   logic pin_cond;
   logic enable_d;

   localparam int ONOFF_PU = pmbus_regs_pkg::ONOFF_POWERUP_BIT - 1;
   localparam int ONOFF_CMD = pmbus_regs_pkg::ONOFF_CMD_EN_BIT - 1;
   localparam int ONOFF_PIN = pmbus_regs_pkg::ONOFF_PIN_EN_BIT - 1;
   localparam int ONOFF_POL = pmbus_regs_pkg::ONOFF_POLARITY_BIT - 1;

   assign pin_active = ~(pin_s2_q ^ onoff_q[ONOFF_POL]);
   assign cmd_cond = !onoff_q[ONOFF_CMD] || op_on_q;
   assign pin_cond = !onoff_q[ONOFF_PIN] || pin_active;
   // Policy bit clear means run whenever powered; set needs both conditions
   assign enable_d = !onoff_q[ONOFF_PU] || (cmd_cond && pin_cond);

   // No ramp-down sequencing: the enable drops on the next edge
   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         device_enable_q <= 1'b0;
      end else begin
         device_enable_q <= enable_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path

   logic [15:0] rd_data_d;
   logic rd_hit;

   always_comb begin
      rd_data_d = 16'h0000;
      rd_hit = 1'b1;
      case (cmd_req.code)
         pmbus_regs_pkg::CODE_OPERATION:
            rd_data_d = {8'h00, pmbus_regs_pkg::OPERATION_FIXED | {op_on_q, 7'h00}};
         pmbus_regs_pkg::CODE_ONOFF_CFG: rd_data_d = {11'h000, onoff_q, 1'b1};
         pmbus_regs_pkg::CODE_WRITE_LOCK: rd_data_d = {8'h00, lock_q, 5'h00};
         pmbus_regs_pkg::CODE_BUS_CAPS:
            rd_data_d = {8'h00, pmbus_regs_pkg::CAPS_VALUE};
         pmbus_regs_pkg::CODE_VOUT_FORMAT:
            rd_data_d = {8'h00, pmbus_regs_pkg::FORMAT_MODE_LINEAR, 2'b00, format_exp_q};
         pmbus_regs_pkg::CODE_VOUT_SETPOINT: rd_data_d = {4'h0, setpoint_mant_q};
         pmbus_regs_pkg::CODE_LOOP_SCALE: rd_data_d = loop_scale_q;
         pmbus_regs_pkg::CODE_MONITOR_SCALE:
            rd_data_d = {2'b00, monitor_scale_q[12:10], 1'b0, monitor_scale_q[9:0]};
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rd_valid_q <= 1'b0;
         rd_miss_q <= 1'b0;
         rd_data_q <= 16'h0000;
      end else begin
         rd_valid_q <= host_read;
         rd_miss_q <= host_read && !rd_hit;
         if (host_read) begin
            rd_data_q <= rd_data_d;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   sequence read_of(logic [7:0] want);
      host_read && cmd_req.code == want;
   endsequence

   sequence send_of(logic [7:0] want);
      host_send && cmd_req.code == want && !nv_load.valid;
   endsequence

   chk_caps_value: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
      read_of(pmbus_regs_pkg::CODE_BUS_CAPS) |=> rd_valid_q && rd_data_q == 16'h0020)
      else $error("capability read value wrong");

   chk_powerdown_reads_one: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
      read_of(pmbus_regs_pkg::CODE_ONOFF_CFG) |=> rd_data_q[0] && rd_data_q[15:5] == 11'h000)
      else $error("power-down bit not one");

   chk_setpoint_upper: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
      read_of(pmbus_regs_pkg::CODE_VOUT_SETPOINT) |=>
         rd_data_q[15:12] == 4'h0 && rd_data_q[11:0] == $past(setpoint_mant_q))
      else $error("setpoint readback wrong");

   chk_fault_clear: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
      send_of(pmbus_regs_pkg::CODE_FAULT_CLEAR) |=> fault_clear_q ##1
         fault_clear_q == $past(host_send && cmd_req.code == pmbus_regs_pkg::CODE_FAULT_CLEAR))
      else $error("fault clear pulse wrong");

   chk_store_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
      store_user_q |-> $past(host_send) && $past(cmd_req.code) == 8'h15)
      else $error("store pulse without command");

   chk_lock_all: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
      host_write && lock_q[2] && !nv_load.valid && cmd_req.code == 8'h21 |=>
         $stable(setpoint_mant_q) && wr_reject_q)
      else $error("write passed full lock");

   chk_lock_ops: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
      host_write && lock_q == 3'b010 && !nv_load.valid && cmd_req.code == 8'h01 |=>
         op_on_q == $past(cmd_req.data[7]) && !wr_reject_q)
      else $error("operation write blocked at level two");

   chk_lock_cfg: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
      host_write && lock_q == 3'b001 && !nv_load.valid && cmd_req.code == 8'h29 |=>
         $stable(loop_scale_q) && wr_reject_q)
      else $error("scale write passed level three");

   chk_enable_off: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
      onoff_q[ONOFF_PU] && onoff_q[ONOFF_CMD] && !op_on_q |=> !device_enable_q)
      else $error("enable high with operation off");

   chk_pin_policy: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
      onoff_q[ONOFF_PU] && onoff_q[ONOFF_PIN] && !pin_active |=> !device_enable_q)
      else $error("enable high with pin inactive");

   chk_always_on: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
      !onoff_q[ONOFF_PU] |=> device_enable_q)
      else $error("enable low with power-up policy clear");

endmodule

// File: test/pmbus_host_model.sv
`timescale 1ns/100ps
module pmbus_host_model (
   input wire logic ref_clk,
   output pmbus_regs_pkg::cmd_req_t cmd_req
);

   initial begin
      cmd_req = '0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // One request per call, valid for exactly one cycle; the caller samples the
   // answer one step after the taking edge, when the registered pulses stand
   task automatic do_req(input logic wr, input logic snd, input logic [7:0] code,
                         input logic [15:0] data);
      @(posedge ref_clk);
      #1;
      cmd_req.valid = 1'b1;
      cmd_req.is_write = wr;
      cmd_req.is_send = snd;
      cmd_req.code = code;
      // Send-byte carries no data byte, so the field holds junk
      cmd_req.data = snd ? 16'ha5c3 : data;
      @(posedge ref_clk);
      #1;
      // Released fields show the inverse, never a convenient zero
      cmd_req.valid = 1'b0;
      cmd_req.code = ~code;
      cmd_req.data = ~cmd_req.data;
   endtask

endmodule

// File: test/pmbus_onoff_protect_format_regs_tb_top.sv
`timescale 1ns/100ps
module pmbus_onoff_protect_format_regs_tb_top;
   typedef struct {
      logic wr;
      logic [7:0] code;
      logic [15:0] data;
      logic [15:0] exp;
      logic rej;
   } row_t;

   logic ref_clk, reset_n, pin;
   pmbus_regs_pkg::cmd_req_t cmd_req;
   pmbus_regs_pkg::nv_load_t nv_load;
   logic rd_valid, rd_miss, wr_reject, fault_clear, restore_factory, store_user;
   logic restore_user, page_erase, device_enable;
   logic [15:0] rd_data;
   logic [11:0] setpoint_mant;
   logic [2:0] format_exp;
   int mismatches = 0;
   int n_tests = 0;
   row_t rows [15] = '{
      '{1'b0, 8'h19, 16'h0000, 16'h0020, 1'b0},
      '{1'b0, 8'h02, 16'h0000, 16'h001f, 1'b0},
      '{1'b0, 8'h10, 16'h0000, 16'h0000, 1'b0},
      '{1'b0, 8'h20, 16'h0000, 16'h0000, 1'b0},
      '{1'b0, 8'h01, 16'h0000, 16'h0004, 1'b0},
      '{1'b0, 8'h55, 16'h0000, 16'h0000, 1'b0},
      '{1'b1, 8'h19, 16'h00ff, 16'h0000, 1'b1},
      '{1'b1, 8'h55, 16'h00ff, 16'h0000, 1'b1},
      '{1'b1, 8'h21, 16'hffff, 16'h0000, 1'b0},
      '{1'b0, 8'h21, 16'h0000, 16'h0fff, 1'b0},
      '{1'b1, 8'h29, 16'hffff, 16'h0000, 1'b0},
      '{1'b0, 8'h29, 16'h0000, 16'hfbff, 1'b0},
      '{1'b1, 8'h2a, 16'hffff, 16'h0000, 1'b0},
      '{1'b0, 8'h2a, 16'h0000, 16'h3bff, 1'b0},
      '{1'b1, 8'h20, 16'h00ff, 16'h0000, 1'b0}};
   logic [7:0] sc [5] = '{8'h03, 8'h12, 8'h15, 8'h16, 8'h55};
   logic [7:0] lc [8] = '{8'h01, 8'h02, 8'h21, 8'h20, 8'h29, 8'h2a, 8'hd0, 8'h10};
   // Writable codes under lock bits 7, 6, 5, indexed like lc
   logic [7:0] am [3] = '{8'h80, 8'hc1, 8'hc7};

   pmbus_host_model host (.ref_clk(ref_clk), .cmd_req(cmd_req));

   pmbus_onoff_protect_format_regs DUT (
      .ref_clk(ref_clk), .reset_n(reset_n), .cmd_req(cmd_req), .nv_load(nv_load),
      .supply_on_request_pin(pin), .rd_valid_q(rd_valid), .rd_data_q(rd_data),
      .rd_miss_q(rd_miss), .wr_reject_q(wr_reject), .fault_clear_q(fault_clear),
      .restore_factory_q(restore_factory), .store_user_q(store_user),
      .restore_user_q(restore_user), .page_erase_q(page_erase),
      .device_enable_q(device_enable), .setpoint_mant_q(setpoint_mant),
      .format_exp_q(format_exp));

   ////////////////////////////////////////////////////////////////////////////
   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp1(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t flag %b expected %b", $time, got, exp);
      end
   endtask

   task automatic nv_put(input logic [7:0] code, input logic [15:0] data);
      @(posedge ref_clk);
      #1;
      nv_load = '{1'b1, code, data};
      @(posedge ref_clk);
      #1;
      nv_load = '{1'b0, ~code, ~data};
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // Whole run is about 680 cycles; the 15000-cycle limit leaves a wide margin
   initial begin
      #60000;
      mismatches++;
      $display("[ERR] %0t watchdog expired", $time);
      test_done();
   end

   initial begin
      logic [11:0] sp_model;
      logic [7:0] lv;
      logic act;
      reset_n = 1'b0;
      pin = 1'b0;
      nv_load = '0;
      repeat (16) @(posedge ref_clk);
      #1;
      reset_n = 1'b1;
      repeat (3) @(posedge ref_clk);
      foreach (rows[i]) begin
         host.do_req(rows[i].wr, 1'b0, rows[i].code, rows[i].data);
         cmp1(wr_reject, rows[i].rej);
         if (!rows[i].wr) begin
            cmp1(rd_valid, 1'b1);
            cmp1(rd_miss, rows[i].code == 8'h55);
            cmp16(rd_data, rows[i].exp);
         end
      end
      host.do_req(1'b0, 1'b0, pmbus_regs_pkg::CODE_VOUT_FORMAT, 16'h0000);
      cmp16(rd_data, 16'h0007);
      cmp16({1'b0, format_exp, setpoint_mant}, 16'h7fff);
      $display("test table done");

      for (int c = 0; c < 16; c++)
         for (int p = 0; p < 2; p++)
            for (int o = 0; o < 2; o++) begin
               @(posedge ref_clk);
               #1;
               pin = p[0];
               host.do_req(1'b1, 1'b0, pmbus_regs_pkg::CODE_ONOFF_CFG, {11'h0, c[3:0], 1'b1});
               host.do_req(1'b1, 1'b0, pmbus_regs_pkg::CODE_OPERATION, {8'h0, o[0], 7'h7f});
               repeat (3) @(posedge ref_clk);
               #1;
               act = (p[0] == c[0]);
               cmp1(device_enable, !c[3] || ((!c[2] || o[0]) && (!c[1] || act)));
            end
      // Enabled now (last combination); off must land exactly two edges after the write
      host.do_req(1'b1, 1'b0, pmbus_regs_pkg::CODE_OPERATION, 16'h0000);
      cmp1(device_enable, 1'b1);
      @(posedge ref_clk);
      #1;
      cmp1(device_enable, 1'b0);
      host.do_req(1'b1, 1'b0, pmbus_regs_pkg::CODE_OPERATION, 16'h0080);
      repeat (2) @(posedge ref_clk);
      #1;
      pin = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      cmp1(device_enable, 1'b1);
      @(posedge ref_clk);
      #1;
      cmp1(device_enable, 1'b0);
      host.do_req(1'b0, 1'b0, pmbus_regs_pkg::CODE_OPERATION, 16'h0000);
      cmp16(rd_data, 16'h0084);
      $display("test enable done");

      // is_write is set as well, since a send must ignore it
      for (int i = 0; i < 5; i++) begin
         host.do_req(1'b1, 1'b1, sc[i], 16'h0000);
         cmp16({12'h0, fault_clear, restore_factory, store_user, restore_user},
               i < 4 ? 16'h0008 >> i : 16'h0000);
         cmp1(wr_reject, 1'b0);
         @(posedge ref_clk);
         #1;
         cmp16({12'h0, fault_clear, restore_factory, store_user, restore_user}, 16'h0);
      end
      $display("test send done");

      sp_model = 12'hfff;
      for (int l = 0; l < 3; l++) begin
         lv = 8'h80 >> l;
         host.do_req(1'b1, 1'b0, pmbus_regs_pkg::CODE_WRITE_LOCK, {8'h0, lv});
         host.do_req(1'b0, 1'b0, pmbus_regs_pkg::CODE_WRITE_LOCK, 16'h0000);
         cmp16(rd_data, {8'h0, lv});
         for (int i = 0; i < 8; i++) begin
            host.do_req(1'b1, 1'b0, lc[i], i == 7 ? {8'h0, lv} : 16'h001e);
            cmp1(wr_reject, !am[l][i]);
            if (i == 6)
               cmp1(page_erase, am[l][i]);
            if (i == 2) begin
               if (am[l][i])
                  sp_model = 12'h01e;
               host.do_req(1'b0, 1'b0, pmbus_regs_pkg::CODE_VOUT_SETPOINT, 16'h0000);
               cmp16(rd_data, {4'h0, sp_model});
            end
         end
      end
      // Loader and host hit the setpoint in one cycle; the loader wins
      fork
         host.do_req(1'b1, 1'b0, pmbus_regs_pkg::CODE_VOUT_SETPOINT, 16'h0444);
         nv_put(pmbus_regs_pkg::CODE_VOUT_SETPOINT, 16'h0333);
      join
      cmp16({4'h0, setpoint_mant}, 16'h0333);
      host.do_req(1'b1, 1'b0, pmbus_regs_pkg::CODE_WRITE_LOCK, 16'h0080);
      nv_put(pmbus_regs_pkg::CODE_LOOP_SCALE, 16'h1234);
      host.do_req(1'b0, 1'b0, pmbus_regs_pkg::CODE_LOOP_SCALE, 16'h0000);
      cmp16(rd_data, 16'h1234);
      $display("test lock done");

      @(posedge ref_clk);
      #1;
      reset_n = 1'b0;
      #1;
      cmp16({rd_data[14:0], device_enable}, 16'h0);
      repeat (4) @(posedge ref_clk);
      #1;
      reset_n = 1'b1;
      repeat (3) @(posedge ref_clk);
      host.do_req(1'b0, 1'b0, pmbus_regs_pkg::CODE_ONOFF_CFG, 16'h0000);
      cmp16(rd_data, 16'h001f);
      host.do_req(1'b1, 1'b0, pmbus_regs_pkg::CODE_LOOP_SCALE, 16'h0001);
      cmp1(wr_reject, 1'b0);
      $display("test reset done");
      test_done();
   end

endmodule
